//--- design/otg_session_control_status.sv
// OTG session control and status register with protocol end flags.
// Assumes a classic Wishbone master, a protocol engine that reports
// negotiation and session request outcomes as one-cycle pulses, and
// asynchronous comparator, ID and mode levels from outside the clock domain.
//
// Notes on behaviour
// - B-device role shows B-session valid comparator at bit 19.
// - A-device role shows A-session valid comparator at bit 18.
// - Host mode shows debounce type at bit 17, long or short.
// - ID pin level at bit 16 always; 0 A-device, 1 B-device.
// - Device negotiation enable bit 11 gates starting negotiation in device mode.
// - Host negotiation enable bit 10 gates response to B-device requests.
// - Negotiation request bit 9 starts negotiation in device mode.
// - Negotiation success bit 8 set on success, cleared when request set.
// - Session request bit 1 starts session request; clears like negotiation request.
// - Session request success bit 0 set on success, cleared when request set.
// - Negotiation end flag at bit 9 of interrupt flags on completion.
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module otg_session_control_status
	import otg_session_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        wbCycI,
	input  wire logic        wbStbI,
	input  wire logic        wbWeI,
	input  wire logic [7:0]  wbAdrI,
	input  wire logic [3:0]  wbSelI,
	input  wire logic [31:0] wbDatI,
	output logic      [31:0] wbDatO,
	output logic             wbAckO,
	input  wire logic        bSessionThreshold,
	input  wire logic        aSessionThreshold,
	input  wire logic        idPinState,
	input  wire logic        hostMode,
	input  wire logic        shortDebounce,
	input  wire logic        negDone,
	input  wire logic        negOk,
	input  wire logic        sessDone,
	input  wire logic        sessOk,
	input  wire logic        peerNegRequest,
	output logic             startNegotiation,
	output logic             startSession,
	output logic             acceptPeerNeg,
	output logic             irq
);
	import otg_session_pkg::*;

	// ==========================================
	// Reset release
	logic rstMeta_q;
	logic rstSync_q;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	wire rstN = rstSync_q;

	// ==========================================
	// Pin synchronisers, one per asynchronous level
	localparam int NSYNC = 5;
	wire  [NSYNC-1:0] pinsRaw = {shortDebounce, hostMode, idPinState,
		aSessionThreshold, bSessionThreshold};
	logic [NSYNC-1:0] pinMeta_q;
	logic [NSYNC-1:0] pinSync_q;
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge clock or negedge rstN)
			begin
				if (!rstN)
				begin
					pinMeta_q[gi] <= 1'b0;
					pinSync_q[gi] <= 1'b0;
				end
				else
				begin
					pinMeta_q[gi] <= pinsRaw[gi];
					pinSync_q[gi] <= pinMeta_q[gi];
				end
			end
		end
	endgenerate
	wire bSessS   = pinSync_q[0];
	wire aSessS   = pinSync_q[1];
	wire idS      = pinSync_q[2];
	wire hostS    = pinSync_q[3];
	wire shortS   = pinSync_q[4];
	wire devMode  = !hostS;
	wire roleB    = idS;

	// ==========================================
	// Bus decode
	wire busReq    = wbCycI && wbStbI && !wbAckO;
	wire selCtrl   = (wbAdrI == OFS_CTRL_STATUS);
	wire selFlags  = (wbAdrI == OFS_INT_FLAGS);
	wire selMask   = (wbAdrI == OFS_INT_MASK);
	// Writes commit at the edge where the master samples ack, never on the take edge
	wire busDone   = wbCycI && wbStbI && wbAckO;
	wire wrFull    = busDone && wbWeI && (wbSelI == 4'hf);
	wire wrCtrl    = wrFull && selCtrl;
	wire wrFlags   = wrFull && selFlags;
	wire wrMask    = wrFull && selMask;

	// ==========================================
	// Control bits
	logic devNegEn_q, hostNegEn_q, negReq_q, negOk_q, sessReq_q, sessOk_q;
	logic negEnd_q, sessEnd_q;
	logic [31:0] mask_q;

	// Writes only land while the matching mode is active
	wire wrDevCtrl  = wrCtrl && devMode;
	wire wrHostCtrl = wrCtrl && hostS;
	wire clrNegEnd  = wrFlags && wbDatI[BIT_NEG_END];
	wire clrSessEnd = wrFlags && wbDatI[BIT_SESS_END];
	wire negReqRise  = wrDevCtrl && wbDatI[BIT_NEG_REQ] && !negReq_q;
	wire sessReqRise = wrDevCtrl && wbDatI[BIT_SESS_REQ] && !sessReq_q;

	always_ff @(posedge clock or negedge rstN)
	begin
		if (!rstN)
		begin
			devNegEn_q  <= 1'b0;
			hostNegEn_q <= 1'b0;
			negReq_q    <= 1'b0;
			sessReq_q   <= 1'b0;
		end
		else
		begin
			if (wrDevCtrl)
			begin
				devNegEn_q <= wbDatI[BIT_DEV_NEG_EN];
				negReq_q   <= wbDatI[BIT_NEG_REQ];
				sessReq_q  <= wbDatI[BIT_SESS_REQ];
			end
			else
			begin
				if (clrNegEnd && negEnd_q)
					negReq_q <= 1'b0;
				if (clrSessEnd && sessEnd_q)
					sessReq_q <= 1'b0;
			end
			if (wrHostCtrl)
				hostNegEn_q <= wbDatI[BIT_HOST_NEG_EN];
		end
	end

	// Success bits: a fresh request clears, an outcome loads its result
	always_ff @(posedge clock or negedge rstN)
	begin
		if (!rstN)
		begin
			negOk_q  <= 1'b0;
			sessOk_q <= 1'b0;
		end
		else
		begin
			if (negReqRise)
				negOk_q <= 1'b0;
			else if (negDone)
				negOk_q <= negOk;
			if (sessReqRise)
				sessOk_q <= 1'b0;
			else if (sessDone)
				sessOk_q <= sessOk;
		end
	end

	// ==========================================
	// End flags, set wins over write-one-to-clear
	always_ff @(posedge clock or negedge rstN)
	begin
		if (!rstN)
		begin
			negEnd_q  <= 1'b0;
			sessEnd_q <= 1'b0;
			mask_q    <= RESET_MASK;
		end
		else
		begin
			negEnd_q  <= negDone || (negEnd_q && !clrNegEnd);
			sessEnd_q <= sessDone || (sessEnd_q && !clrSessEnd);
			if (wrMask)
				mask_q <= wbDatI;
		end
	end

	wire [31:0] flagsWord = {22'h00_0000, negEnd_q, sessEnd_q, 8'h00};
	assign irq = |(flagsWord & mask_q);

	// ==========================================
	// Protocol controls toward the engine
	assign startNegotiation = devMode && negReq_q && devNegEn_q;
	assign startSession     = devMode && sessReq_q;
	assign acceptPeerNeg    = hostS && hostNegEn_q && peerNegRequest;

	// ==========================================
	// Read view; mode-restricted bits read zero
	logic [31:0] ctrlWord;
	always_comb
	begin
		ctrlWord = RESET_CTRL;
		ctrlWord[BIT_B_SESS_VALID] = roleB && bSessS;
		ctrlWord[BIT_A_SESS_VALID] = !roleB && aSessS;
		ctrlWord[BIT_DEBOUNCE]     = hostS && shortS;
		ctrlWord[BIT_ID_PIN]       = idS;
		ctrlWord[BIT_DEV_NEG_EN]   = devMode && devNegEn_q;
		ctrlWord[BIT_HOST_NEG_EN]  = hostS && hostNegEn_q;
		ctrlWord[BIT_NEG_REQ]      = devMode && negReq_q;
		ctrlWord[BIT_NEG_OK]       = devMode && negOk_q;
		ctrlWord[BIT_SESS_REQ]     = devMode && sessReq_q;
		ctrlWord[BIT_SESS_OK]      = devMode && sessOk_q;
	end

	wire [31:0] readMux = selCtrl ? ctrlWord :
		selFlags ? flagsWord :
		selMask ? mask_q : READ_UNMAPPED;

	always_ff @(posedge clock or negedge rstN)
	begin
		if (!rstN)
		begin
			wbAckO <= 1'b0;
			wbDatO <= 32'h0000_0000;
		end
		else
		begin
			wbAckO <= busReq;
			if (busReq && !wbWeI)
				wbDatO <= readMux;
		end
	end

	// ==========================================
	// Checks
	sequence s_req_write;
		wrDevCtrl && wbDatI[BIT_NEG_REQ] && !negReq_q;
	endsequence

	sequence s_neg_outcome;
		negDone && !negReqRise;
	endsequence

	sequence s_sess_outcome;
		sessDone && !sessReqRise;
	endsequence

	a_neg_ok_clear: assert property (@(posedge clock) disable iff (!rstN)
		s_req_write |=> !negOk_q)
		else $error("negotiation success not cleared by request");

	a_neg_ok_load: assert property (@(posedge clock) disable iff (!rstN)
		s_neg_outcome |=> negOk_q == $past(negOk))
		else $error("negotiation outcome not recorded");

	a_sess_ok_clear: assert property (@(posedge clock) disable iff (!rstN)
		sessReqRise |=> !sessOk_q)
		else $error("session success not cleared by request");

	a_sess_ok_load: assert property (@(posedge clock) disable iff (!rstN)
		s_sess_outcome |=> sessOk_q == $past(sessOk))
		else $error("session outcome not recorded");

	a_neg_end_set: assert property (@(posedge clock) disable iff (!rstN)
		negDone |=> negEnd_q)
		else $error("negotiation end flag not set");

	a_neg_end_clear: assert property (@(posedge clock) disable iff (!rstN)
		clrNegEnd && !negDone |=> !negEnd_q)
		else $error("negotiation end flag not cleared");

	a_sess_end_set: assert property (@(posedge clock) disable iff (!rstN)
		sessDone |=> sessEnd_q)
		else $error("session end flag not set");

	a_neg_gate: assert property (@(posedge clock) disable iff (!rstN)
		startNegotiation |-> devNegEn_q && !hostS)
		else $error("negotiation started without enable");

	a_peer_gate: assert property (@(posedge clock) disable iff (!rstN)
		!hostNegEn_q |-> !acceptPeerNeg)
		else $error("peer request accepted while disabled");

	a_id_view: assert property (@(posedge clock) disable iff (!rstN)
		busReq && selCtrl && !wbWeI |=> wbAckO && wbDatO[BIT_ID_PIN] == $past(idS))
		else $error("id pin state misreported");

	a_role_b_only: assert property (@(posedge clock) disable iff (!rstN)
		!roleB |-> !ctrlWord[BIT_B_SESS_VALID])
		else $error("b-session valid shown in a-role");

	a_role_a_only: assert property (@(posedge clock) disable iff (!rstN)
		roleB |-> !ctrlWord[BIT_A_SESS_VALID])
		else $error("a-session valid shown in b-role");

	a_debounce_host: assert property (@(posedge clock) disable iff (!rstN)
		!hostS |-> !ctrlWord[BIT_DEBOUNCE])
		else $error("debounce type shown outside host mode");

	a_req_clear_end: assert property (@(posedge clock) disable iff (!rstN)
		clrNegEnd && negEnd_q && !wrDevCtrl |=> !negReq_q)
		else $error("request not cleared with end flag");

	a_req_write_zero: assert property (@(posedge clock) disable iff (!rstN)
		wrDevCtrl && !wbDatI[BIT_NEG_REQ] |=> !negReq_q)
		else $error("request not cleared by writing zero");

	a_sess_clear_end: assert property (@(posedge clock) disable iff (!rstN)
		clrSessEnd && sessEnd_q && !wrDevCtrl |=> !sessReq_q)
		else $error("session request not cleared with end flag");

	a_sess_start: assert property (@(posedge clock) disable iff (!rstN)
		wrDevCtrl && wbDatI[BIT_SESS_REQ] |=> startSession)
		else $error("session request not started");

	a_mode_write: assert property (@(posedge clock) disable iff (!rstN)
		wrCtrl && hostS |=> $stable(negReq_q))
		else $error("device bit written in host mode");

	a_host_en_keep: assert property (@(posedge clock) disable iff (!rstN)
		wrCtrl && devMode |=> $stable(hostNegEn_q))
		else $error("host bit written in device mode");

	a_host_bits_zero: assert property (@(posedge clock) disable iff (!rstN)
		hostS |-> !ctrlWord[BIT_DEV_NEG_EN] && !ctrlWord[BIT_NEG_REQ]
			&& !ctrlWord[BIT_NEG_OK] && !ctrlWord[BIT_SESS_REQ] && !ctrlWord[BIT_SESS_OK])
		else $error("device bits shown in host mode");

	a_neg_req_start: assert property (@(posedge clock) disable iff (!rstN)
		wrDevCtrl && wbDatI[BIT_NEG_REQ] && wbDatI[BIT_DEV_NEG_EN] ##1 devMode
		|-> startNegotiation)
		else $error("negotiation request not started");

endmodule

//--- design/otg_session_pkg.sv
// Constants for the OTG session control and status block.
// Assumes a 32-bit classic Wishbone register bus with word addressing in bytes.
package otg_session_pkg;

	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
	localparam logic [7:0] OFS_INT_FLAGS   = 8'h04;
	localparam logic [7:0] OFS_INT_MASK    = 8'h08;

	// ==========================================
	// Control and status field positions
	localparam int BIT_B_SESS_VALID = 19;
	localparam int BIT_A_SESS_VALID = 18;
	localparam int BIT_DEBOUNCE     = 17;
	localparam int BIT_ID_PIN       = 16;
	localparam int BIT_DEV_NEG_EN   = 11;
	localparam int BIT_HOST_NEG_EN  = 10;
	localparam int BIT_NEG_REQ      = 9;
	localparam int BIT_NEG_OK       = 8;
	localparam int BIT_SESS_REQ     = 1;
	localparam int BIT_SESS_OK      = 0;

	// ==========================================
	// Interrupt flag positions
	localparam int BIT_NEG_END  = 9;
	localparam int BIT_SESS_END = 8;

	localparam logic [31:0] RESET_CTRL  = 32'h0000_0000;
	localparam logic [31:0] RESET_FLAGS = 32'h0000_0000;
	localparam logic [31:0] RESET_MASK  = 32'h0000_0000;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

endpackage

//--- dv/otg_peer_model.sv
// Behavioural far-side peer and protocol engine for the OTG session block.
// Assumes the bench sets the wanted outcome and the peer's negotiation request.
`timescale 1ns/1ps
module otg_peer_model #(
	parameter int LAT = 4
)
(
	input  wire logic clock,
	input  wire logic startNegotiation,
	input  wire logic startSession,
	input  wire logic wantOk,
	input  wire logic peerAsk,
	output logic      negDone,
	output logic      negOk,
	output logic      sessDone,
	output logic      sessOk,
	output logic      peerNegRequest
);
	logic [3:0] negCnt  = '0;
	logic [3:0] sessCnt = '0;
	logic       negPrev = 1'b0;
	logic       sessPrev = 1'b0;
	// ==========================================
	// One end pulse per rising request, LAT cycles later
	always_ff @(posedge clock)
	begin
		negPrev <= startNegotiation;
		sessPrev <= startSession;
		negCnt <= (startNegotiation && !negPrev) ? 4'(LAT) : (negCnt != 0 ? negCnt - 1 : negCnt);
		sessCnt <= (startSession && !sessPrev) ? 4'(LAT) : (sessCnt != 0 ? sessCnt - 1 : sessCnt);
	end
	assign negDone = (negCnt == 4'h1);
	assign sessDone = (sessCnt == 4'h1);
	// Outcome lines carry no meaning outside the pulse, so show the inverse there
	assign negOk = negDone ? wantOk : !wantOk;
	assign sessOk = sessDone ? wantOk : !wantOk;
	assign peerNegRequest = peerAsk;
endmodule

//--- dv/otg_session_control_status_tb_top.sv
// Self-checking bench for the OTG session control and status block.
// Assumes the design package and a 20 MHz clock; pins are given 4 cycles to settle.
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin numErrors++; \
	$display("Error %0t: got %h expected %h", $time, a, b); end end
module otg_session_control_status_tb_top;
	import otg_session_pkg::*;
	logic clock = 0, nrst = 0, wbCycI = 0, wbStbI = 0, wbWeI = 0;
	logic [7:0] wbAdrI = '0;
	logic [3:0] wbSelI = '0;
	logic [31:0] wbDatI = '0, wbDatO;
	logic wbAckO, bSessionThreshold = 0, aSessionThreshold = 0, idPinState = 0;
	logic hostMode = 0, shortDebounce = 0, negDone, negOk, sessDone, sessOk;
	logic peerNegRequest, startNegotiation, startSession, acceptPeerNeg, irq;
	logic wantOk = 0, peerAsk = 0;
	int numErrors = 0, nChecks = 0, cycles = 0;
	otg_session_control_status otg_session_control_status_i (.*);
	otg_peer_model #(.LAT(4)) otg_peer_model_i (.*);
	always #25 clock = !clock;
	// ==========================================
	// Bus tasks
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		wbCycI <= 1; wbStbI <= 1; wbWeI <= we; wbAdrI <= a; wbDatI <= d; wbSelI <= 4'hf;
		do @(posedge clock); while (wbAckO !== 1'b1);
		r = wbDatO;
		wbCycI <= 0; wbStbI <= 0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0000_0000, r);
		`CHK(r, e)
	endtask
	task automatic pins(input logic [4:0] v);
		{idPinState, bSessionThreshold, aSessionThreshold, hostMode, shortDebounce} <= v;
		repeat (4) @(posedge clock);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		rd(OFS_CTRL_STATUS, RESET_CTRL);
		rd(OFS_INT_FLAGS, RESET_FLAGS);
		rd(OFS_INT_MASK, RESET_MASK);
		rd(8'h0c, READ_UNMAPPED);
	endtask
	task automatic t_status();
		logic [31:0] e;
		for (int i = 0; i < 32; i++)
		begin
			pins(i[4:0]);
			e = {12'h000, i[4] & i[3], !i[4] & i[2], i[1] & i[0], i[4], 16'h0000};
			rd(OFS_CTRL_STATUS, e);
		end
	endtask
	task automatic t_neg();
		pins(5'b10000);
		wantOk <= 1;
		wr(OFS_CTRL_STATUS, 32'h0000_0200);
		`CHK(startNegotiation, 1'b0)
		wr(OFS_CTRL_STATUS, 32'h0000_0a00);
		`CHK(startNegotiation, 1'b1)
		repeat (10) @(posedge clock);
		rd(OFS_INT_FLAGS, 32'h0000_0200);
		rd(OFS_CTRL_STATUS, 32'h0001_0b00);
		`CHK(irq, 1'b0)
		wr(OFS_INT_MASK, 32'h0000_0200);
		`CHK(irq, 1'b1)
		wr(OFS_INT_FLAGS, 32'h0000_0200);
		`CHK(irq, 1'b0)
		rd(OFS_CTRL_STATUS, 32'h0001_0900);
		wantOk <= 0;
		wr(OFS_CTRL_STATUS, 32'h0000_0a00);
		rd(OFS_CTRL_STATUS, 32'h0001_0a00);
		wr(OFS_CTRL_STATUS, 32'h0000_0800);
		`CHK(startNegotiation, 1'b0)
		repeat (10) @(posedge clock);
		`CHK(irq, 1'b1)
		rd(OFS_CTRL_STATUS, 32'h0001_0800);
	endtask
	task automatic t_sess();
		wantOk <= 0;
		wr(OFS_CTRL_STATUS, 32'h0000_0002);
		`CHK(startSession, 1'b1)
		repeat (10) @(posedge clock);
		rd(OFS_CTRL_STATUS, 32'h0001_0002);
		wr(OFS_CTRL_STATUS, 32'h0000_0000);
		wantOk <= 1;
		wr(OFS_CTRL_STATUS, 32'h0000_0002);
		repeat (10) @(posedge clock);
		rd(OFS_CTRL_STATUS, 32'h0001_0003);
		wr(OFS_INT_FLAGS, 32'h0000_0100);
		`CHK(startSession, 1'b0)
		wr(OFS_CTRL_STATUS, 32'h0000_0002);
		rd(OFS_CTRL_STATUS, 32'h0001_0002);
	endtask
	task automatic t_host();
		pins(5'b00010);
		peerAsk <= 1;
		wr(OFS_CTRL_STATUS, 32'h0000_0f03);
		rd(OFS_CTRL_STATUS, 32'h0000_0400);
		`CHK(startNegotiation, 1'b0)
		`CHK(acceptPeerNeg, 1'b1)
		wr(OFS_CTRL_STATUS, 32'h0000_0000);
		`CHK(acceptPeerNeg, 1'b0)
	endtask
	// ==========================================
	// Verdict, timeout and main sequence
	task automatic complete_run();
		$display("Checks %0d errors %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			numErrors++;
			complete_run();
		end
	end
	initial
	begin
		repeat (2) @(posedge clock);
		nrst <= 1;
		repeat (6) @(posedge clock);
		t_reset();
		t_status();
		t_neg();
		t_sess();
		t_host();
		complete_run();
	end
endmodule
